// [psc_defs.svh]
// Timing counts, thresholds and field codes for the punch sequence controller.
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_CLK_MHZ          100
`define PSC_PUNCH_HOME_MS    205
`define PSC_PUNCH_HOME_CYC   (`PSC_PUNCH_HOME_MS * 1000 * `PSC_CLK_MHZ)
`define PSC_NEAR_FULL_CNT    5
`define PSC_FULL_CNT         1000
`define PSC_ADV_CYC          1000
`define PSC_REV_CYC          1000
`define PSC_JAM_NONE         2'h0
`define PSC_JAM_HOLE         2'h1
`define PSC_JAM_PUNCH_MOTOR  2'h2
`define PSC_JAM_SLIDE_MOTOR  2'h3
`define PSC_CAM_HOME         2'h0
`define PSC_CAM_PUNCH_A      2'h1
`define PSC_CAM_MID          2'h2
`define PSC_CAM_PUNCH_B      2'h3
`endif

// [psc_pkg.sv]
// Types shared by the punch sequence controller.
package psc_pkg;
  typedef struct packed {
    logic       slide_run;
    logic       slide_to_home;
    logic       punch_run;
    logic       feed_run;
    logic       feed_reverse;
  } psc_motor_t;
  typedef struct packed {
    logic       waste_near_full;
    logic       waste_full;
    logic [1:0] cam_phase;
    logic       slide_home;
    logic       entrance;
    logic       busy;
  } psc_status_t;
endpackage

// [psc_punch_sequence_controller.sv]
// Punch unit sequence controller: slide, punch, waste and jam logic.
`timescale 1ns/1ps
`include "psc_defs.svh"

// Summary of operation
// - Sheet at entrance sensor starts slide motor travelling toward rear.
// - Slide stops when edge sensor sees sheet edge for host paper size.
// - Speed mode: advance preset distance past entrance edge, stop, punch.
// - Precision mode: advance past trailing edge, reverse to stopper, punch.
// - After punch, feed sheet onward and return slide to home sensor.
// - In punch mode repeat the whole sequence for every entering sheet.
// - Cam phase comes from the two punch home sensor states.
// - After punching, dark waste sensor counts as a full reading.
// - Five consecutive full readings declare waste near-full.
// - 1,000 consecutive full readings declare waste full.
// - Full reading when the front cover closes declares full at once.
// - Full reading at power-on declares waste full at once.
// - Punch that has left home and is not back home within 205 ms raises punched-hole jam.
// - Each new punch motor fault occurrence raises punch motor jam.
// - A new slide motor fault raises slide motor jam when no punch motor fault rises in the same cycle.
// - Controller commands; device drives motors and reports sensor states.
module psc_punch_sequence_controller #(
  parameter int unsigned PUNCH_HOME_CYC = `PSC_PUNCH_HOME_CYC,
  parameter int unsigned ADV_CYC        = `PSC_ADV_CYC,
  parameter int unsigned REV_CYC        = `PSC_REV_CYC,
  parameter int unsigned FULL_CNT       = `PSC_FULL_CNT
) (
  // Clock, reset and enable.
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // Commands from the finisher controller.
  input  wire logic                punch_mode,
  input  wire logic                precision_mode,
  input  wire logic [2:0]          paper_size,
  input  wire logic                jam_clear,
  input  wire logic                cover_closed,
  // Sensor pins.
  input  wire logic                entrance_sensor,
  input  wire logic                slide_home_sensor,
  input  wire logic [4:0]          edge_sensor_receiver,
  input  wire logic                punch_home_sensor_a,
  input  wire logic                punch_home_sensor_b,
  input  wire logic                waste_full_sensor,
  input  wire logic                punch_motor_fault,
  input  wire logic                slide_motor_fault,
  // Motor drives and emitter.
  output psc_pkg::psc_motor_t      motor,
  output logic                     edge_sensor_emitter,
  // Status and jam report.
  output psc_pkg::psc_status_t     status,
  output logic [1:0]               jam_code
);

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_SLIDE  = 8'h02,
    S_ADV    = 8'h04,
    S_REV    = 8'h08,
    S_PUNCH  = 8'h10,
    S_EJECT  = 8'h20,
    S_HOME   = 8'h40,
    S_JAM    = 8'h80
  } psc_state_t;

  psc_state_t  state_reg;
  logic [31:0] tmr_reg;
  logic [9:0]  full_cnt_reg;
  logic        near_full_reg;
  logic        full_reg;
  logic [1:0]  pon_cnt_reg;
  logic [2:0]  size_reg;
  psc_pkg::psc_status_t status_reg;
  logic        cover_d_reg;
  logic        pm_flt_d_reg;
  logic        sm_flt_d_reg;
  logic        left_home_reg;
  logic        chk_reg;
  logic [1:0]  jam_reg;
  logic [1:0]  jam_next;
  logic [10:0] s1_reg;
  logic [10:0] s2_reg;

  // Sensor aliases after the two-stage synchroniser.
  logic       ent;
  logic       shome;
  logic [4:0] edge_rx;
  logic       ph_a;
  logic       ph_b;
  logic       wfull;
  logic       pm_flt;
  logic       sm_flt;
  logic       edge_hit;
  logic       cam_home;

  function automatic logic sel_bit(input logic [4:0] v,
                                   input logic [2:0] idx);
    sel_bit = (idx < 3'h5) ? v[idx] : 1'b0;
  endfunction

  // A fault counts once per rising edge, so a fault that stays on does not
  // raise the jam again after the controller has cleared it.
  function automatic logic new_fault(input logic now_lvl,
                                     input logic was_lvl);
    new_fault = now_lvl & ~was_lvl;
  endfunction

  // Two flip-flops on every sensor pin before logic reads it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // The waste bit resets to light received, never to a full reading.
      s1_reg <= 11'h100;
      s2_reg <= 11'h100;
    end else if (clk_en) begin
      s1_reg <= {slide_motor_fault, punch_motor_fault, waste_full_sensor,
                 punch_home_sensor_b, punch_home_sensor_a,
                 edge_sensor_receiver, slide_home_sensor};
      s2_reg <= s1_reg;
    end
  end

  assign shome    = s2_reg[0];
  assign edge_rx  = s2_reg[5:1];
  assign ph_a     = s2_reg[6];
  assign ph_b     = s2_reg[7];
  assign wfull    = ~s2_reg[8];
  assign pm_flt   = s2_reg[9];
  assign sm_flt   = s2_reg[10];

  logic ent_s1_reg;
  logic ent_s2_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ent_s1_reg <= 1'b0;
      ent_s2_reg <= 1'b0;
    end else if (clk_en) begin
      ent_s1_reg <= entrance_sensor;
      ent_s2_reg <= ent_s1_reg;
    end
  end
  assign ent = ent_s2_reg;

  // The paper size is taken while idle, so a late host change cannot move
  // the stop position of a slide that is already travelling.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      size_reg <= 3'h0;
    end else if (clk_en) begin
      if (state_reg == S_IDLE) begin
        size_reg <= paper_size;
      end
    end
  end

  assign edge_hit = sel_bit(edge_rx, size_reg);
  assign cam_home = ph_a & ph_b;

  // Jam code from faults; a new fault edge or hole timeout sets it.
  always_comb begin
    jam_next = jam_reg;
    if (jam_clear) begin
      jam_next = `PSC_JAM_NONE;
    end
    if (state_reg == S_PUNCH && left_home_reg &&
        tmr_reg >= PUNCH_HOME_CYC) begin
      jam_next = `PSC_JAM_HOLE;
    end
    if (new_fault(sm_flt, sm_flt_d_reg)) begin
      jam_next = `PSC_JAM_SLIDE_MOTOR;
    end
    if (new_fault(pm_flt, pm_flt_d_reg)) begin
      jam_next = `PSC_JAM_PUNCH_MOTOR;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      jam_reg      <= `PSC_JAM_NONE;
      pm_flt_d_reg <= 1'b0;
      sm_flt_d_reg <= 1'b0;
    end else if (clk_en) begin
      jam_reg      <= jam_next;
      pm_flt_d_reg <= pm_flt;
      sm_flt_d_reg <= sm_flt;
    end
  end

  // Sheet sequence.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= S_IDLE;
      tmr_reg       <= 32'h0000_0000;
      left_home_reg <= 1'b0;
      chk_reg       <= 1'b0;
    end else if (clk_en) begin
      tmr_reg <= tmr_reg + 32'h0000_0001;
      chk_reg <= 1'b0;
      if (jam_reg != `PSC_JAM_NONE && state_reg != S_JAM) begin
        state_reg <= S_JAM;
      end else begin
        unique case (state_reg)
          S_IDLE: begin
            if (punch_mode && ent) begin
              state_reg <= S_SLIDE;
            end
          end
          S_SLIDE: begin
            if (edge_hit) begin
              state_reg <= S_ADV;
              tmr_reg   <= 32'h0000_0000;
            end
          end
          S_ADV: begin
            if (precision_mode) begin
              if (ent) begin
                tmr_reg <= 32'h0000_0000;
              end else if (tmr_reg >= ADV_CYC) begin
                state_reg <= S_REV;
                tmr_reg   <= 32'h0000_0000;
              end
            end else if (tmr_reg >= ADV_CYC) begin
              state_reg     <= S_PUNCH;
              tmr_reg       <= 32'h0000_0000;
              left_home_reg <= 1'b0;
            end
          end
          S_REV: begin
            if (tmr_reg >= REV_CYC) begin
              state_reg     <= S_PUNCH;
              tmr_reg       <= 32'h0000_0000;
              left_home_reg <= 1'b0;
            end
          end
          S_PUNCH: begin
            if (!cam_home) begin
              left_home_reg <= 1'b1;
            end else if (left_home_reg) begin
              state_reg <= S_EJECT;
              chk_reg   <= 1'b1;
            end
          end
          S_EJECT: begin
            if (!ent) begin
              state_reg <= S_HOME;
            end
          end
          S_HOME: begin
            if (shome) begin
              state_reg <= S_IDLE;
            end
          end
          S_JAM: begin
            if (jam_reg == `PSC_JAM_NONE) begin
              state_reg <= S_HOME;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // Waste tray level detection.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      full_cnt_reg  <= 10'h000;
      near_full_reg <= 1'b0;
      full_reg      <= 1'b0;
      pon_cnt_reg   <= 2'h3;
      cover_d_reg   <= 1'b0;
    end else if (clk_en) begin
      cover_d_reg <= cover_closed;
      // The power-on check waits until the synchroniser holds the real pin.
      if (pon_cnt_reg != 2'h0) begin
        pon_cnt_reg <= pon_cnt_reg - 2'h1;
      end
      if (pon_cnt_reg == 2'h1 && wfull) begin
        full_reg <= 1'b1;
      end
      if (cover_closed && !cover_d_reg && wfull) begin
        full_reg <= 1'b1;
      end
      if (chk_reg) begin
        if (!wfull) begin
          full_cnt_reg  <= 10'h000;
          near_full_reg <= 1'b0;
        end else begin
          if (full_cnt_reg != 10'h3ff) begin
            full_cnt_reg <= full_cnt_reg + 10'h001;
          end
          if (full_cnt_reg + 10'h001 >= 10'(`PSC_NEAR_FULL_CNT)) begin
            near_full_reg <= 1'b1;
          end
          if (full_cnt_reg + 10'h001 >= 10'(FULL_CNT)) begin
            full_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Motor drives and status report.
  always_comb begin
    motor.slide_run     = (state_reg == S_SLIDE) || (state_reg == S_HOME);
    motor.slide_to_home = (state_reg == S_HOME);
    motor.punch_run     = (state_reg == S_PUNCH);
    motor.feed_run      = (state_reg == S_ADV) || (state_reg == S_REV) ||
                          (state_reg == S_EJECT);
    motor.feed_reverse  = (state_reg == S_REV);
  end

  assign edge_sensor_emitter = (state_reg == S_SLIDE);

  // Status is registered so the controller always reads settled levels.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else if (clk_en) begin
      status_reg.waste_near_full <= near_full_reg;
      status_reg.waste_full      <= full_reg;
      status_reg.cam_phase       <= {ph_b, ph_a};
      status_reg.slide_home      <= shome;
      status_reg.entrance        <= ent;
      status_reg.busy            <= (state_reg != S_IDLE);
    end
  end

  assign status = status_reg;

  assign jam_code = jam_reg;

endmodule // psc_punch_sequence_controller

// [psc_checker.sv]
// Port checker for the punch sequence controller.
`timescale 1ns/1ps
module psc_checker (
  // Clock and reset.
  input wire logic                 clock,
  input wire logic                 rst_n,
  // Commands.
  input wire logic                 punch_mode,
  input wire logic [2:0]           paper_size,
  input wire logic                 jam_clear,
  input wire logic                 cover_closed,
  // Sensors.
  input wire logic                 entrance_sensor,
  input wire logic                 slide_home_sensor,
  input wire logic [4:0]           edge_sensor_receiver,
  input wire logic                 punch_home_sensor_a,
  input wire logic                 punch_home_sensor_b,
  input wire logic                 waste_full_sensor,
  input wire logic                 punch_motor_fault,
  input wire logic                 slide_motor_fault,
  // Controller outputs.
  input wire psc_pkg::psc_motor_t  motor,
  input wire psc_pkg::psc_status_t status,
  input wire logic [1:0]           jam_code
);
  logic [1:0] cam_now;
  assign cam_now = {punch_home_sensor_b, punch_home_sensor_a};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence edge_s;
    (motor.slide_run && !motor.slide_to_home && paper_size < 3'h5
      && edge_sensor_receiver[paper_size])[*3];
  endsequence
  sequence full_s;
    (!waste_full_sensor)[*4] ##0 $rose(cover_closed);
  endsequence
  slide_start_a: assert property (
    punch_mode && !status.busy && jam_code == 2'h0 ##1 $rose(entrance_sensor)
    |-> ##[1:4] motor.slide_run) else $error("Slide did not start.");
  edge_stop_a: assert property (
    edge_s |-> ##[0:2] !motor.slide_run) else $error("Slide kept going.");
  home_stop_a: assert property (
    (motor.slide_to_home && slide_home_sensor)[*3] |=> !motor.slide_to_home)
    else $error("Slide passed home.");
  cam_phase_a: assert property (
    ($stable(cam_now))[*4] |-> status.cam_phase == cam_now)
    else $error("Cam phase wrong.");
  jam_hold_a: assert property (
    (jam_code != 2'h0 && !jam_clear)[*4] |=> jam_code != 2'h0)
    else $error("Jam dropped.");
  punch_jam_a: assert property (
    $rose(punch_motor_fault) |-> ##[2:5] jam_code == 2'h2)
    else $error("No punch motor jam.");
  slide_jam_a: assert property (
    $rose(slide_motor_fault) && !punch_motor_fault
    |-> ##[2:5] jam_code == 2'h3) else $error("No slide motor jam.");
  cover_full_a: assert property (
    full_s |-> ##[1:5] status.waste_full) else $error("Full missed.");
endmodule // psc_checker
bind psc_punch_sequence_controller psc_checker psc_checker_inst (
  .clock, .rst_n, .punch_mode, .paper_size, .jam_clear, .cover_closed,
  .entrance_sensor, .slide_home_sensor, .edge_sensor_receiver,
  .punch_home_sensor_a, .punch_home_sensor_b, .waste_full_sensor,
  .punch_motor_fault, .slide_motor_fault, .motor, .status, .jam_code);

// [psc_mech_model.sv]
// Mechanics model: slide travel, edge and home sensors, punch cam.
`timescale 1ns/1ps
module psc_mech_model (
  // Clock and drives.
  input  wire logic                clock,
  input  wire psc_pkg::psc_motor_t motor,
  input  wire logic [2:0]          paper_size,
  input  wire logic                stuck,
  // Sensor pins.
  output logic                     slide_home_sensor,
  output logic [4:0]               edge_sensor_receiver,
  output logic                     punch_home_sensor_a,
  output logic                     punch_home_sensor_b
);
  logic [5:0] pos_reg = 6'h0;
  logic [3:0] cam_reg = 4'h0;
  logic       done_reg = 1'b0;
  always_ff @(posedge clock) begin
    if (motor.slide_run && motor.slide_to_home && pos_reg != 6'h0)
      pos_reg <= pos_reg - 6'h1;
    else if (motor.slide_run && !motor.slide_to_home && pos_reg != 6'h3f)
      pos_reg <= pos_reg + 6'h1;
  end
  // The cam turns one lap per punch; a stuck cam freezes off home.
  always_ff @(posedge clock) begin
    done_reg <= motor.punch_run && (done_reg || cam_reg == 4'hf);
    if (motor.punch_run && !done_reg && !(stuck && cam_reg != 4'h0))
      cam_reg <= cam_reg + 4'h1;
  end
  assign slide_home_sensor = (pos_reg == 6'h0);
  assign edge_sensor_receiver = (pos_reg > 6'h5 && paper_size < 3'h5)
    ? 5'h1 << paper_size : 5'h0;
  assign punch_home_sensor_a = (cam_reg < 4'h8);
  assign punch_home_sensor_b = (cam_reg == 4'h0 || cam_reg > 4'h8);
endmodule // psc_mech_model

// [psc_punch_sequence_controller_tb_top.sv]
// Self-checking testbench for the punch sequence controller.
`timescale 1ns/1ps
module psc_punch_sequence_controller_tb_top;
  localparam int FC = 8;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, punch_mode = 1'b0;
  logic precision_mode = 1'b0, jam_clear = 1'b0, cover_closed = 1'b0;
  logic entrance_sensor = 1'b0, waste_full_sensor = 1'b1, stuck = 1'b0;
  logic punch_motor_fault = 1'b0, slide_motor_fault = 1'b0;
  logic slide_home_sensor, punch_home_sensor_a, punch_home_sensor_b;
  logic edge_sensor_emitter;
  logic [2:0] paper_size = 3'h0;
  logic [4:0] edge_sensor_receiver;
  logic [1:0] jam_code;
  logic [6:0] ev;
  psc_pkg::psc_motor_t motor;
  psc_pkg::psc_status_t status;
  int fail_count = 0, cmp_count = 0, run = 0;
  psc_punch_sequence_controller #(.PUNCH_HOME_CYC(200), .ADV_CYC(10),
    .REV_CYC(10), .FULL_CNT(FC)) psc_punch_sequence_controller_inst (
    .clock, .rst_n, .clk_en, .punch_mode, .precision_mode, .paper_size,
    .jam_clear, .cover_closed, .entrance_sensor, .slide_home_sensor,
    .edge_sensor_receiver, .punch_home_sensor_a, .punch_home_sensor_b,
    .waste_full_sensor, .punch_motor_fault, .slide_motor_fault, .motor,
    .edge_sensor_emitter, .status, .jam_code);
  psc_mech_model psc_mech_model_inst (.clock, .motor, .paper_size, .stuck,
    .slide_home_sensor, .edge_sensor_receiver, .punch_home_sensor_a,
    .punch_home_sensor_b);
  always #5 clock = ~clock;
  assign ev = {motor.feed_run & ~motor.slide_run, jam_code != 2'h0,
    ~status.busy, motor.slide_to_home, motor.punch_run,
    motor.feed_reverse, motor.slide_run};
  function automatic logic [1:0] ge(int r, int l);
    return 2'(r >= l);
  endfunction
  task automatic chk(string n, logic [1:0] e, logic [1:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wt(int s);
    for (int i = 0; i < 900 && ev[s] !== 1'b1; i++)
      cyc(1);
    if (ev[s] !== 1'b1) begin
      chk("wait", 2'h1, 2'h0);
      end_sim();
    end
  endtask
  task automatic rst(logic lit);
    @(posedge clock) rst_n <= 1'b0;
    waste_full_sensor <= lit;
    entrance_sensor <= 1'b0;
    cyc(20);
    @(posedge clock) rst_n <= 1'b1;
    cyc(4);
  endtask
  task automatic sheet(logic pr, logic lit);
    @(posedge clock) precision_mode <= pr;
    waste_full_sensor <= lit;
    paper_size <= 3'($urandom_range(4));
    @(posedge clock) entrance_sensor <= 1'b1;
    wt(0);
    chk("emitter", 2'h1, edge_sensor_emitter);
    wt(6);
    if (pr) begin
      @(posedge clock) entrance_sensor <= 1'b0;
      wt(1);
    end
    wt(2);
    @(posedge clock) entrance_sensor <= 1'b0;
    wt(3);
    wt(4);
    chk("slide_home", 2'h1, status.slide_home);
    chk("entrance", 2'h0, status.entrance);
  endtask
  initial begin
    void'($urandom(29));
    rst(1'b1);
    chk("waste_full", 2'h0, status.waste_full);
    chk("jam_code", 2'h0, jam_code);
    @(posedge clock) punch_mode <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      sheet(i[0], i == 3);
      run = (i == 3) ? 0 : run + 1;
      chk("near_full", ge(run, 5), status.waste_near_full);
      chk("waste_full", ge(run, FC), status.waste_full);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) punch_motor_fault <= (i != 1);
      slide_motor_fault <= (i == 1);
      cyc(4);
      @(posedge clock) {punch_motor_fault, slide_motor_fault} <= 2'h0;
      cyc(20);
      chk("jam_code", (i == 1) ? 2'h3 : 2'h2, jam_code);
      @(posedge clock) jam_clear <= 1'b1;
      @(posedge clock) jam_clear <= 1'b0;
      cyc(6);
      chk("jam_code", 2'h0, jam_code);
      wt(4);
    end
    @(posedge clock) stuck <= 1'b1;
    precision_mode <= 1'b0;
    @(posedge clock) entrance_sensor <= 1'b1;
    wt(2);
    cyc(150);
    chk("hole_jam", 2'h0, jam_code);
    wt(5);
    chk("hole_jam", 2'h1, jam_code);
    rst(1'b0);
    chk("waste_full", 2'h1, status.waste_full);
    rst(1'b1);
    @(posedge clock) waste_full_sensor <= 1'b0;
    cyc(8);
    chk("waste_full", 2'h0, status.waste_full);
    @(posedge clock) cover_closed <= 1'b1;
    cyc(8);
    chk("waste_full", 2'h1, status.waste_full);
    end_sim();
  end
endmodule // psc_punch_sequence_controller_tb_top
